//--- hdl/gdfs_pkg.sv
package gdfs_pkg;

    // Register addresses (7-bit command address)
    localparam logic [6:0] GDFS_ADDR_OVERCURRENT = 7'h01;
    localparam logic [6:0] GDFS_ADDR_GATE_FAULT = 7'h02;
    localparam logic [6:0] GDFS_ADDR_SUPPLY = 7'h03;

    // Reset values
    localparam logic [15:0] GDFS_RESET_VALUE = 16'h0000;

    // Overcurrent status field positions
    localparam int GDFS_POS_COUNTER_ACTIVE = 15;
    localparam int GDFS_POS_SENSE_A = 10;
    localparam int GDFS_POS_SENSE_C = 8;
    localparam int GDFS_POS_DS_HIGH = 5;
    localparam int GDFS_POS_DS_LOW = 0;

    // Supply status field positions
    localparam int GDFS_POS_SUPPLY_HIGH = 15;
    localparam int GDFS_POS_SUPPLY_LOW = 8;
    localparam int GDFS_POS_BOOT_HIGH = 5;
    localparam int GDFS_POS_BOOT_LOW = 0;

    // Frame layout: command byte then 16 data bits (no CRC here)
    localparam int GDFS_FRAME_BITS = 24;
    localparam int GDFS_CMD_BITS = 8;
    localparam logic GDFS_RW_READ = 1'b1;

    // Cycle counter width
    localparam int GDFS_CNT_W = 8;

    // Monitor inputs, MSB first in register order
    typedef struct packed {
        logic [2:0] sense_oc;   // phase A, B, C
        logic [5:0] ds_oc;      // AH, AL, BH, BL, CH, CL
        logic [5:0] gate_fault; // AH, AL, BH, BL, CH, CL
        logic [7:0] supply;     // ov/uv pairs: power, drain, pump, gate
        logic [5:0] bootstrap;  // ov/uv pairs: A, B, C
    } gdfs_mon_t;

    typedef enum logic [1:0] {
        GDFS_IDLE,
        GDFS_CMD,
        GDFS_DATA
    } gdfs_state_t;

endpackage

//--- hdl/gdfs_status_regs.sv
// Functional notes
// RULE1: Count limiter events while limiting enabled
// RULE2: Bit 15 high when counter nonzero
// RULE3: Bits 10..8 sense overcurrent phases A..C
// RULE4: Bits 5..0 drain-source overcurrent per MOSFET
// RULE5: Address 2 bits 5..0 gate faults
// RULE6: Address 1 resets zero, read-only
// RULE7: Address 2 resets zero, read-only
// RULE8: Address 3 bits 15..8 supply pairs
// RULE9: Address 3 bits 5..0 bootstrap pairs
// RULE10: Summary drain-source bit ORs all bits
// RULE11: Read via command word, same-frame data
`timescale 1ns/1ps
module gdfs_status_regs
    import gdfs_pkg::*;
(
    // Clock and reset
    input wire logic CLK,
    input wire logic NRST,
    // Analog monitor levels and cycle counter controls
    input wire gdfs_mon_t MON,
    input wire logic CYCLE_LIMIT_ENABLE,
    input wire logic CYCLE_COUNTER_CLEAR,
    // SPI slave pins
    input wire logic SCLK,
    input wire logic NSCS,
    input wire logic SDI,
    output logic SDO,
    output logic SDO_OE_N,
    // Summary output
    output logic DRAIN_SOURCE_OVERCURRENT
);

    logic [15:0] oc_reg;
    logic [15:0] gate_reg;
    logic [15:0] supply_reg;
    logic [GDFS_CNT_W-1:0] count_reg;
    gdfs_mon_t mon_s1_reg;
    gdfs_mon_t mon_reg;
    logic [2:0] sclk_sync_reg;
    logic [1:0] cs_sync_reg;
    logic sdi_s1_reg;
    logic sdi_reg;
    gdfs_state_t state_reg;
    logic [4:0] bit_cnt_reg;
    logic [7:0] cmd_reg;
    logic [15:0] shift_reg;
    logic [8:0] event_prev_reg;
    logic sclk_rise;
    logic sclk_fall;
    logic [8:0] event_now;
    logic cmd_done;

    function automatic logic [15:0] read_mux(input logic [6:0] addr);
        logic [15:0] value;
        value = 16'h0000;
        if (addr == GDFS_ADDR_OVERCURRENT)
            value = oc_reg;
        else if (addr == GDFS_ADDR_GATE_FAULT)
            value = gate_reg;
        else if (addr == GDFS_ADDR_SUPPLY)
            value = supply_reg;
        return value;
    endfunction

    // Synchronise monitors and pins
    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            mon_s1_reg <= '0;
            mon_reg <= '0;
            sclk_sync_reg <= 3'h0;
            cs_sync_reg <= 2'h3;
            sdi_s1_reg <= 1'b0;
            sdi_reg <= 1'b0;
        end
        else
        begin
            mon_s1_reg <= MON;
            mon_reg <= mon_s1_reg;
            sclk_sync_reg <= {sclk_sync_reg[1:0], SCLK};
            cs_sync_reg <= {cs_sync_reg[0], NSCS};
            sdi_s1_reg <= SDI;
            sdi_reg <= sdi_s1_reg;
        end
    end

    assign sclk_rise = sclk_sync_reg[1] && !sclk_sync_reg[2];
    assign sclk_fall = !sclk_sync_reg[1] && sclk_sync_reg[2];

    // Status registers, reserved bits stay zero
    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            oc_reg <= GDFS_RESET_VALUE; // RULE6
            gate_reg <= GDFS_RESET_VALUE; // RULE7
            supply_reg <= GDFS_RESET_VALUE; // RULE8
        end
        else
        begin
            oc_reg <= GDFS_RESET_VALUE;
            oc_reg[GDFS_POS_COUNTER_ACTIVE] <= (count_reg != '0); // RULE2
            oc_reg[GDFS_POS_SENSE_A:GDFS_POS_SENSE_C]
                <= mon_reg.sense_oc; // RULE3
            oc_reg[GDFS_POS_DS_HIGH:GDFS_POS_DS_LOW] <= mon_reg.ds_oc; // RULE4
            gate_reg <= {10'h000, mon_reg.gate_fault}; // RULE5
            supply_reg <= GDFS_RESET_VALUE;
            supply_reg[GDFS_POS_SUPPLY_HIGH:GDFS_POS_SUPPLY_LOW]
                <= mon_reg.supply; // RULE8
            supply_reg[GDFS_POS_BOOT_HIGH:GDFS_POS_BOOT_LOW]
                <= mon_reg.bootstrap; // RULE9
        end
    end

    // Rising edges of any overcurrent monitor count as events
    assign event_now = {mon_reg.sense_oc, mon_reg.ds_oc};

    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            event_prev_reg <= 9'h000;
            count_reg <= '0;
        end
        else
        begin
            event_prev_reg <= event_now;
            if (CYCLE_LIMIT_ENABLE && |(event_now & ~event_prev_reg))
            begin
                if (count_reg != '1)
                    count_reg <= count_reg + 1'b1; // RULE1
            end
            else if (CYCLE_COUNTER_CLEAR || !CYCLE_LIMIT_ENABLE)
                count_reg <= '0;
        end
    end

    // Summary drain-source bit
    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
            DRAIN_SOURCE_OVERCURRENT <= 1'b0;
        else
            DRAIN_SOURCE_OVERCURRENT <= |mon_reg.ds_oc; // RULE10
    end

    // SPI frame engine: writes are ignored, registers are read-only
    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            state_reg <= GDFS_IDLE;
            bit_cnt_reg <= 5'h00;
            cmd_reg <= 8'h00;
            shift_reg <= 16'h0000;
            SDO <= 1'b0;
            SDO_OE_N <= 1'b1;
        end
        else if (cs_sync_reg[1])
        begin
            state_reg <= GDFS_IDLE;
            SDO_OE_N <= 1'b1;
            SDO <= 1'b0;
        end
        else
        begin
            case (state_reg)
                GDFS_IDLE:
                begin
                    state_reg <= GDFS_CMD;
                    bit_cnt_reg <= 5'h00;
                    SDO_OE_N <= 1'b0;
                    SDO <= 1'b0;
                end
                GDFS_CMD:
                begin
                    if (sclk_fall)
                    begin
                        cmd_reg <= {cmd_reg[6:0], sdi_reg};
                        bit_cnt_reg <= bit_cnt_reg + 5'h01;
                        if (bit_cnt_reg == 5'(GDFS_CMD_BITS - 1))
                        begin
                            // RULE11
                            shift_reg <= read_mux(cmd_reg[6:0]);
                            state_reg <= GDFS_DATA;
                        end
                    end
                    else if (sclk_rise && bit_cnt_reg != 5'h00)
                        SDO <= cmd_reg[0]; // RULE11
                end
                GDFS_DATA:
                begin
                    if (sclk_rise)
                    begin
                        SDO <= shift_reg[15]; // RULE11
                        shift_reg <= {shift_reg[14:0], 1'b0};
                    end
                    if (sclk_fall && bit_cnt_reg != 5'(GDFS_FRAME_BITS))
                        bit_cnt_reg <= bit_cnt_reg + 5'h01;
                end
                default:
                    state_reg <= GDFS_IDLE;
            endcase
        end
    end

    a_counter_flag: assert property ( // RULE2
        @(posedge CLK) disable iff (!NRST)
        1'b1 |=> oc_reg[GDFS_POS_COUNTER_ACTIVE] == ($past(count_reg) != '0))
        else $error("counter activity flag wrong");

    a_counter_incr: assert property ( // RULE1
        @(posedge CLK) disable iff (!NRST)
        (CYCLE_LIMIT_ENABLE && |(event_now & ~event_prev_reg)
            && count_reg != '1) |=> count_reg == $past(count_reg) + 1'b1)
        else $error("counter did not increment");

    a_sense_bits: assert property ( // RULE3
        @(posedge CLK) disable iff (!NRST)
        1'b1 |=> oc_reg[10:8] == $past(mon_reg.sense_oc))
        else $error("sense bits mismatch");

    a_ds_bits: assert property ( // RULE4
        @(posedge CLK) disable iff (!NRST)
        1'b1 |=> oc_reg[5:0] == $past(mon_reg.ds_oc) && oc_reg[14:11] == 4'h0
            && oc_reg[7:6] == 2'h0)
        else $error("drain-source bits mismatch");

    a_gate_bits: assert property ( // RULE5
        @(posedge CLK) disable iff (!NRST)
        1'b1 |=> gate_reg == {10'h000, $past(mon_reg.gate_fault)})
        else $error("gate fault register mismatch");

    a_supply_bits: assert property ( // RULE8
        @(posedge CLK) disable iff (!NRST)
        1'b1 |=> supply_reg[15:8] == $past(mon_reg.supply))
        else $error("supply bits mismatch");

    a_boot_bits: assert property ( // RULE9
        @(posedge CLK) disable iff (!NRST)
        1'b1 |=> supply_reg[5:0] == $past(mon_reg.bootstrap)
            && supply_reg[7:6] == 2'h0)
        else $error("bootstrap bits mismatch");

    a_summary_or: assert property ( // RULE10
        @(posedge CLK) disable iff (!NRST)
        1'b1 |=> DRAIN_SOURCE_OVERCURRENT == $past(|mon_reg.ds_oc))
        else $error("summary bit not set");

    a_sdo_release: assert property ( // RULE11
        @(posedge CLK) disable iff (!NRST)
        cs_sync_reg[1] |=> SDO_OE_N)
        else $error("sdo driven outside frame");

    // Last command bit taken, read data loaded
    assign cmd_done = !cs_sync_reg[1] && state_reg == GDFS_CMD && sclk_fall
        && bit_cnt_reg == 5'(GDFS_CMD_BITS - 1);

    a_reset_oc: assert property ( // RULE6
        @(posedge CLK)
        !NRST |=> oc_reg == GDFS_RESET_VALUE)
        else $error("overcurrent register not zero in reset");

    a_reset_gate: assert property ( // RULE7
        @(posedge CLK)
        !NRST |=> gate_reg == GDFS_RESET_VALUE)
        else $error("gate fault register not zero in reset");

    a_reset_supply: assert property ( // RULE8
        @(posedge CLK)
        !NRST |=> supply_reg == GDFS_RESET_VALUE)
        else $error("supply register not zero in reset");

    a_counter_clear: assert property ( // RULE1
        @(posedge CLK) disable iff (!NRST)
        (!CYCLE_LIMIT_ENABLE || (CYCLE_COUNTER_CLEAR
            && !(|(event_now & ~event_prev_reg)))) |=> count_reg == '0)
        else $error("counter not cleared");

    a_counter_hold: assert property ( // RULE1
        @(posedge CLK) disable iff (!NRST)
        (CYCLE_LIMIT_ENABLE && !CYCLE_COUNTER_CLEAR
            && !(|(event_now & ~event_prev_reg))) |=> $stable(count_reg))
        else $error("counter moved without an event");

    a_frame_start: assert property ( // RULE11
        @(posedge CLK) disable iff (!NRST)
        !cs_sync_reg[1] && state_reg == GDFS_IDLE |=> !SDO_OE_N && !SDO)
        else $error("frame start slot wrong");

    a_sdo_echo: assert property ( // RULE11
        @(posedge CLK) disable iff (!NRST)
        (!cs_sync_reg[1] && state_reg == GDFS_CMD && sclk_rise
            && bit_cnt_reg != 5'h00) |=> SDO == $past(cmd_reg[0]))
        else $error("address echo wrong");

    a_read_oc: assert property ( // RULE11
        @(posedge CLK) disable iff (!NRST)
        cmd_done && cmd_reg[6:0] == GDFS_ADDR_OVERCURRENT
            |=> state_reg == GDFS_DATA && shift_reg == $past(oc_reg))
        else $error("overcurrent read data wrong");

    a_read_gate: assert property ( // RULE11
        @(posedge CLK) disable iff (!NRST)
        cmd_done && cmd_reg[6:0] == GDFS_ADDR_GATE_FAULT
            |=> state_reg == GDFS_DATA && shift_reg == $past(gate_reg))
        else $error("gate fault read data wrong");

    a_read_supply: assert property ( // RULE11
        @(posedge CLK) disable iff (!NRST)
        cmd_done && cmd_reg[6:0] == GDFS_ADDR_SUPPLY
            |=> state_reg == GDFS_DATA && shift_reg == $past(supply_reg))
        else $error("supply read data wrong");

    a_read_unmapped: assert property ( // RULE11
        @(posedge CLK) disable iff (!NRST)
        cmd_done && (cmd_reg[6:0] == 7'h00
            || cmd_reg[6:0] > GDFS_ADDR_SUPPLY) |=> shift_reg == 16'h0000)
        else $error("unmapped address not zero");

    a_data_shift: assert property ( // RULE11
        @(posedge CLK) disable iff (!NRST)
        (!cs_sync_reg[1] && state_reg == GDFS_DATA && sclk_rise)
            |=> SDO == $past(shift_reg[15]))
        else $error("read data bit out of order");

endmodule

//--- test/gdfs_spi_master.sv
`timescale 1ns/1ps
module gdfs_spi_master
    import gdfs_pkg::*;
(
    // Clock
    input wire logic CLK,
    // SPI pins
    output logic SCLK,
    output logic NSCS,
    output logic SDI,
    input wire logic SDO,
    input wire logic SDO_OE_N
);
    localparam int HALF = 6;
    initial
    begin
        SCLK = 1'b0;
        NSCS = 1'b1;
        SDI = 1'b0;
    end
    task automatic xfer(input logic [6:0] addr, input logic rw,
        input logic [15:0] data, output logic [23:0] rx);
        logic [23:0] tx;
        tx = {addr, rw, data};
        NSCS <= 1'b0;
        repeat (HALF) @(posedge CLK);
        for (int i = 23; i >= 0; i--)
        begin
            SDI <= tx[i];
            SCLK <= 1'b1;
            repeat (HALF) @(posedge CLK);
            SCLK <= 1'b0;
            // Released line reads as inverse
            rx[i] = SDO_OE_N ? ~SDO : SDO;
            repeat (HALF) @(posedge CLK);
        end
        NSCS <= 1'b1;
        SDI <= ~SDI;
        repeat (4 * HALF) @(posedge CLK);
    endtask
endmodule

//--- test/tb_gdfs_status_regs.sv
`timescale 1ns/1ps
`define CHK(got, want) \
    begin \
        checks++; \
        if ((got) !== (want)) \
        begin \
            n_errors++; \
            $display("unexpected at %0t: %0h vs %0h", $time, got, want); \
        end \
    end
module tb_gdfs_status_regs import gdfs_pkg::*;;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    gdfs_mon_t mon = '0;
    logic en = 1'b0;
    logic clr = 1'b0;
    logic sclk, nscs, sdi, sdo, sdo_oe_n, ds_sum, act = 1'b0;
    logic [23:0] rx;
    int n_errors = 0;
    int checks = 0;
    int cycles = 0;
    integer seed = 24;
    gdfs_status_regs i_gdfs_status_regs (.CLK(clk), .NRST(nrst), .MON(mon),
        .CYCLE_LIMIT_ENABLE(en), .CYCLE_COUNTER_CLEAR(clr), .SCLK(sclk),
        .NSCS(nscs), .SDI(sdi), .SDO(sdo), .SDO_OE_N(sdo_oe_n),
        .DRAIN_SOURCE_OVERCURRENT(ds_sum));
    gdfs_spi_master i_gdfs_spi_master (.CLK(clk), .SCLK(sclk), .NSCS(nscs),
        .SDI(sdi), .SDO(sdo), .SDO_OE_N(sdo_oe_n));
    always #10 clk = ~clk;
    task summarize;
        $display("errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 30000)
        begin
            n_errors++;
            summarize();
        end
    end
    function automatic logic [15:0] exp_reg(logic [6:0] a, gdfs_mon_t m,
        logic f);
        case (a)
            GDFS_ADDR_OVERCURRENT: return {f, 4'h0, m.sense_oc, 2'h0, m.ds_oc};
            GDFS_ADDR_GATE_FAULT: return {10'h000, m.gate_fault};
            GDFS_ADDR_SUPPLY: return {m.supply, 2'h0, m.bootstrap};
            default: return 16'h0000;
        endcase
    endfunction
    task automatic read_check(input logic [6:0] a, input logic rw);
        logic [15:0] d;
        d = 16'($random(seed));
        i_gdfs_spi_master.xfer(a, rw, d, rx);
        `CHK(rx[23:16], {1'b0, a})
        `CHK(rx[15:0], exp_reg(a, mon, act))
    endtask
    initial
    begin
        gdfs_mon_t nxt;
        logic e, c, rise;
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        repeat (4) @(posedge clk);
        for (int a = 1; a < 4; a++)
            read_check(7'(a), GDFS_RW_READ);
        for (int n = 0; n < 24; n++)
        begin
            nxt = (n == 0) ? '1 : gdfs_mon_t'(29'($random(seed)));
            if (n == 1)
                nxt = '0;
            e = (n < 2) ? 1'b1 : 1'($random(seed));
            c = (n % 5 == 4);
            rise = |({nxt.sense_oc, nxt.ds_oc} & ~{mon.sense_oc, mon.ds_oc});
            act = e & ((c ? 1'b0 : act) | rise);
            mon <= nxt;
            en <= e;
            clr <= c;
            @(posedge clk);
            clr <= 1'b0;
            repeat (8) @(posedge clk);
            `CHK(ds_sum, |nxt.ds_oc)
            read_check(GDFS_ADDR_OVERCURRENT, GDFS_RW_READ);
            if (n % 4 == 3)
                read_check(7'($random(seed)), 1'($random(seed)));
            else
                read_check(7'(n % 4 + 1), 1'($random(seed)));
        end
        summarize();
    end
endmodule
